// ---- design/cpsm_ctrl.v ----
// cpu processing state, reset, power-down and mode control
`timescale 1ns/1ps
`include "cpsm_regs.vh"
// Behaviour
// - exactly one of five processing states
// - init pin low enters reset; nmi selects type
// - power-on reset clears everything
// - manual reset spares bus timing, pin function
// - reset fetches start pc and sp
// - interrupt pushes sr, pc then vectors
// - halt with select 0 enters sleep
// - sleep exits by reset, interrupt, dma error
// - halt with select 1 enters standby
// - standby exits only by reset or nmi
// - nmi waits full oscillator settling time
// - standby halts, initialises modules; pins selectable
// - bus released to requester
// - boot pins decode mode and area width
// - reset vectors 0x0/0x4 or 0x8/0xC
// - clear vector base, set mask ones
// - reset type latched on init pin rise
module cpsm_ctrl #(
	parameter SETTLE_CYC = (`CPSM_SETTLE_NS + `CPSM_CLK_NS - 1) / `CPSM_CLK_NS,
	parameter VAW        = 8
) (
	// clock and reset
	input  wire           mclk,
	input  wire           nrst,
	input  wire           clk_en,
	// device pins
	input  wire           chip_init_pin_n,
	input  wire           nmi_pin,
	input  wire [2:0]     boot_config_pins,
	// requests from the cpu core and system
	input  wire           halt_exec,
	input  wire           deep_halt_select,
	input  wire           irq_req,
	input  wire [7:0]     irq_vec_num,
	input  wire [3:0]     irq_level,
	input  wire           dma_addr_err,
	input  wire           bus_req,
	input  wire           io_hiz_select,
	// cpu context
	input  wire [31:0]    cur_pc,
	input  wire [31:0]    cur_sp,
	input  wire [31:0]    cur_sr,
	// vector table load port
	input  wire           vec_wr,
	input  wire [VAW-1:0] vec_wr_idx,
	input  wire [31:0]    vec_wr_data,
	// state outputs
	output reg  [2:0]     cpu_state,
	output reg            cpu_run,
	output reg            clock_run,
	output reg            osc_run,
	output reg            bus_grant,
	output reg            io_hold,
	output reg            io_hiz,
	// resets to other units
	output reg            cpu_rst,
	output reg            module_rst,
	output reg            bus_timing_rst,
	output reg            pin_func_rst,
	output reg            por_flag,
	// exception results
	output reg            stack_wr,
	output reg  [31:0]    stack_addr,
	output reg  [31:0]    stack_data,
	output reg            ctx_load,
	output reg  [31:0]    new_pc,
	output reg  [31:0]    new_sp,
	output reg  [31:0]    vector_base_reg,
	output reg  [3:0]     sr_imask,
	// operating mode
	output reg  [2:0]     op_mode,
	output reg            area0_16bit,
	output reg            area0_rom,
	output reg            prom_mode,
	output reg            mode_reserved
);
	// three-stage pin synchronisers
	reg  [2:0] init_s_r;
	reg  [2:0] nmi_s_r;
	wire       init_low  = ~init_s_r[1] & ~init_s_r[2];
	wire       init_high = init_s_r[1] & init_s_r[2];
	wire       nmi_high  = nmi_s_r[1] & nmi_s_r[2];
	reg        init_lvl_r;
	reg        nmi_lvl_r;
	reg        nmi_prev_r;
	wire       init_rise = init_high & ~init_lvl_r;
	wire       nmi_edge  = nmi_high & ~nmi_prev_r;

	reg  [2:0] st_r;
	reg  [2:0] st_nxt;
	reg  [2:0] ex_r;
	reg        is_reset_r;
	reg        is_por_r;
	reg  [7:0] vnum_r;
	reg  [3:0] vlvl_r;
	reg  [31:0] settle_cnt_r;
	reg        rd_en;
	reg  [VAW-1:0] rd_idx;
	wire [31:0] rd_data;
	localparam [31:0] IDX_POR_PC = `CPSM_VEC_POR_PC >> `CPSM_VEC_SHIFT;
	localparam [31:0] IDX_POR_SP = `CPSM_VEC_POR_SP >> `CPSM_VEC_SHIFT;
	localparam [31:0] IDX_MAN_PC = `CPSM_VEC_MAN_PC >> `CPSM_VEC_SHIFT;
	localparam [31:0] IDX_MAN_SP = `CPSM_VEC_MAN_SP >> `CPSM_VEC_SHIFT;
	localparam [31:0] IDX_DMAERR = `CPSM_VEC_DMAERR >> `CPSM_VEC_SHIFT;
	localparam [31:0] IDX_NMI    = `CPSM_VEC_NMI >> `CPSM_VEC_SHIFT;

	// read address is combinational so the registered data meet the step that uses them
	always @* begin
		rd_en  = 1'b0;
		rd_idx = {VAW{1'b0}};
		if (st_r == `CPSM_ST_EXCP) begin
			case (ex_r)
				`CPSM_EX_IDLE: begin
					rd_en  = is_reset_r;
					rd_idx = is_por_r ? IDX_POR_PC[VAW-1:0] : IDX_MAN_PC[VAW-1:0];
				end
				`CPSM_EX_PUSH_SR: begin
					rd_en  = 1'b1;
					rd_idx = vnum_r[VAW-1:0];
				end
				`CPSM_EX_FETCH1: begin
					rd_en  = 1'b1;
					rd_idx = is_por_r ? IDX_POR_SP[VAW-1:0] : IDX_MAN_SP[VAW-1:0];
				end
				default: rd_en = 1'b0;
			endcase
		end
	end

	cpsm_vec_mem #(.AW(VAW), .DW(32)) u_vec (
		.mclk    (mclk),
		.clk_en  (clk_en),
		.wr_en   (vec_wr),
		.wr_addr (vec_wr_idx),
		.wr_data (vec_wr_data),
		.rd_en   (rd_en),
		.rd_addr (rd_idx),
		.rd_data (rd_data)
	);

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			init_s_r   <= 3'h0;
			nmi_s_r    <= 3'h0;
			init_lvl_r <= 1'b0;
			nmi_lvl_r  <= 1'b1;
			nmi_prev_r <= 1'b0;
		end else if (clk_en) begin
			init_s_r   <= {init_s_r[1:0], chip_init_pin_n};
			nmi_s_r    <= {nmi_s_r[1:0], nmi_pin};
			if (init_high)
				init_lvl_r <= 1'b1;
			else if (init_low)
				init_lvl_r <= 1'b0;
			if (nmi_high)
				nmi_lvl_r <= 1'b1;
			else if (~nmi_s_r[1] & ~nmi_s_r[2])
				nmi_lvl_r <= 1'b0;
			nmi_prev_r <= nmi_high;
		end
	end

	// next processing state; reset always wins
	always @* begin
		st_nxt = st_r;
		case (st_r)
			`CPSM_ST_RESET: if (init_rise) st_nxt = `CPSM_ST_EXCP;
			`CPSM_ST_EXCP: if (ex_r == `CPSM_EX_DONE) st_nxt = `CPSM_ST_EXEC;
			`CPSM_ST_BUSREL: if (!bus_req) st_nxt = `CPSM_ST_EXEC;
			`CPSM_ST_EXEC: begin
				if (halt_exec)
					st_nxt = deep_halt_select ? `CPSM_ST_STANDBY : `CPSM_ST_SLEEP;
				else if (irq_req || dma_addr_err)
					st_nxt = `CPSM_ST_EXCP;
				else if (bus_req)
					st_nxt = `CPSM_ST_BUSREL;
			end
			`CPSM_ST_SLEEP: if (irq_req || dma_addr_err || nmi_edge) st_nxt = `CPSM_ST_EXCP;
			`CPSM_ST_STANDBY: if (nmi_edge) st_nxt = `CPSM_ST_SETTLE;
			`CPSM_ST_SETTLE: if (settle_cnt_r == 32'h0) st_nxt = `CPSM_ST_EXCP;
			default: st_nxt = `CPSM_ST_RESET;
		endcase
		if (init_low)
			st_nxt = `CPSM_ST_RESET;
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_r         <= `CPSM_ST_RESET;
			ex_r         <= `CPSM_EX_IDLE;
			is_reset_r   <= 1'b1;
			is_por_r     <= 1'b1;
			vnum_r       <= 8'h00;
			vlvl_r       <= 4'h0;
			settle_cnt_r <= 32'h0;
			stack_wr     <= 1'b0;
			stack_addr   <= 32'h0;
			stack_data   <= 32'h0;
			ctx_load     <= 1'b0;
			new_pc       <= 32'h0;
			new_sp       <= 32'h0;
			vector_base_reg <= `CPSM_VBR_RESET;
			sr_imask     <= `CPSM_IMASK_ALL;
			por_flag     <= 1'b1;
		end else if (clk_en) begin
			st_r     <= st_nxt;
			stack_wr <= 1'b0;
			ctx_load <= 1'b0;
			if (st_r == `CPSM_ST_RESET && init_rise) begin
				is_reset_r <= 1'b1;
				is_por_r   <= nmi_lvl_r;
				por_flag   <= nmi_lvl_r;
			end
			if (st_r == `CPSM_ST_STANDBY && st_nxt == `CPSM_ST_SETTLE)
				settle_cnt_r <= SETTLE_CYC[31:0] - 32'h1;
			else if (st_r == `CPSM_ST_SETTLE && settle_cnt_r != 32'h0)
				settle_cnt_r <= settle_cnt_r - 32'h1;
			if (st_r != `CPSM_ST_EXCP && st_r != `CPSM_ST_RESET && st_nxt == `CPSM_ST_EXCP) begin
				is_reset_r <= 1'b0;
				if (dma_addr_err && st_r != `CPSM_ST_SETTLE) begin
					vnum_r <= IDX_DMAERR[7:0];
					vlvl_r <= sr_imask;
				end else if (irq_req && st_r != `CPSM_ST_SETTLE) begin
					vnum_r <= irq_vec_num;
					vlvl_r <= irq_level;
				end else begin
					vnum_r <= IDX_NMI[7:0];
					vlvl_r <= `CPSM_IMASK_ALL;
				end
			end
			if (st_r == `CPSM_ST_EXCP) begin
				case (ex_r)
					`CPSM_EX_IDLE: begin
						if (is_reset_r) begin
							ex_r <= `CPSM_EX_FETCH1;
						end else begin
							stack_wr   <= 1'b1;
							stack_addr <= cur_sp - 32'h4;
							stack_data <= cur_sr;
							ex_r       <= `CPSM_EX_PUSH_SR;
						end
					end
					`CPSM_EX_PUSH_SR: begin
						stack_wr   <= 1'b1;
						stack_addr <= cur_sp - 32'h8;
						stack_data <= cur_pc;
						ex_r       <= `CPSM_EX_PUSH_PC;
					end
					`CPSM_EX_PUSH_PC: begin
						new_pc   <= rd_data;
						new_sp   <= cur_sp - 32'h8;
						sr_imask <= vlvl_r;
						ctx_load <= 1'b1;
						ex_r     <= `CPSM_EX_DONE;
					end
					`CPSM_EX_FETCH1: begin
						new_pc <= rd_data;
						ex_r   <= `CPSM_EX_FETCH2;
					end
					`CPSM_EX_FETCH2: begin
						new_sp          <= rd_data;
						vector_base_reg <= `CPSM_VBR_RESET;
						sr_imask        <= `CPSM_IMASK_ALL;
						ctx_load        <= 1'b1;
						ex_r            <= `CPSM_EX_DONE;
					end
					default: ex_r <= `CPSM_EX_IDLE;
				endcase
			end else
				ex_r <= `CPSM_EX_IDLE;
		end
	end

	// derived state outputs, registered
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cpu_state      <= `CPSM_ST_RESET;
			cpu_run        <= 1'b0;
			clock_run      <= 1'b1;
			osc_run        <= 1'b1;
			bus_grant      <= 1'b0;
			io_hold        <= 1'b0;
			io_hiz         <= 1'b0;
			cpu_rst        <= 1'b1;
			module_rst     <= 1'b1;
			bus_timing_rst <= 1'b1;
			pin_func_rst   <= 1'b1;
		end else if (clk_en) begin
			// standby, settle map to power-down; settle is its tail
			cpu_state <= (st_nxt == `CPSM_ST_SETTLE || st_nxt == `CPSM_ST_STANDBY) ? `CPSM_ST_SLEEP : st_nxt;
			cpu_run   <= (st_nxt == `CPSM_ST_EXEC);
			clock_run <= (st_nxt != `CPSM_ST_STANDBY);
			osc_run   <= (st_nxt != `CPSM_ST_STANDBY);
			bus_grant <= (st_nxt == `CPSM_ST_BUSREL);
			io_hold   <= (st_nxt == `CPSM_ST_SLEEP) || (st_nxt == `CPSM_ST_STANDBY && !io_hiz_select);
			io_hiz    <= (st_nxt == `CPSM_ST_STANDBY) && io_hiz_select;
			cpu_rst    <= (st_nxt == `CPSM_ST_RESET);
			module_rst <= (st_nxt == `CPSM_ST_RESET) || (st_nxt == `CPSM_ST_STANDBY);
			// manual reset keeps refresh running
			bus_timing_rst <= (st_nxt == `CPSM_ST_RESET) && nmi_lvl_r;
			pin_func_rst   <= (st_nxt == `CPSM_ST_RESET) && nmi_lvl_r;
		end
	end

	// straps are static by contract, so sampled once after reset release
	reg mode_taken_r;
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mode_taken_r  <= 1'b0;
			op_mode       <= `CPSM_MODE0;
			area0_16bit   <= 1'b0;
			area0_rom     <= 1'b0;
			prom_mode     <= 1'b0;
			mode_reserved <= 1'b0;
		end else if (clk_en && !mode_taken_r) begin
			mode_taken_r  <= 1'b1;
			op_mode       <= boot_config_pins;
			area0_16bit   <= (boot_config_pins == `CPSM_MODE1);
			area0_rom     <= (boot_config_pins == `CPSM_MODE2);
			prom_mode     <= (boot_config_pins == `CPSM_MODE7);
			mode_reserved <= (boot_config_pins != `CPSM_MODE0) && (boot_config_pins != `CPSM_MODE1) &&
			                 (boot_config_pins != `CPSM_MODE2) && (boot_config_pins != `CPSM_MODE7);
		end
	end
endmodule

// ---- design/cpsm_vec_mem.v ----
// small vector table memory with registered read data
`timescale 1ns/1ps
module cpsm_vec_mem #(
	parameter AW = 8,
	parameter DW = 32
) (
	// clock
	input  wire          mclk,
	input  wire          clk_en,
	// write port
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [DW-1:0] wr_data,
	// read port
	input  wire          rd_en,
	input  wire [AW-1:0] rd_addr,
	output reg  [DW-1:0] rd_data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge mclk) begin
		if (clk_en) begin
			if (wr_en)
				mem[wr_addr] <= wr_data;
			if (rd_en)
				rd_data <= mem[rd_addr];
		end
	end
endmodule

// ---- shared/cpsm_regs.vh ----
// constants for the cpu state and power mode controller
`ifndef CPSM_REGS_VH
`define CPSM_REGS_VH
// processing states
`define CPSM_ST_RESET    3'h0
`define CPSM_ST_EXCP     3'h1
`define CPSM_ST_BUSREL   3'h2
`define CPSM_ST_EXEC     3'h3
`define CPSM_ST_SLEEP    3'h4
`define CPSM_ST_STANDBY  3'h5
`define CPSM_ST_SETTLE   3'h6
// exception handling steps
`define CPSM_EX_IDLE     3'h0
`define CPSM_EX_PUSH_SR  3'h1
`define CPSM_EX_PUSH_PC  3'h2
`define CPSM_EX_FETCH1   3'h3
`define CPSM_EX_FETCH2   3'h4
`define CPSM_EX_DONE     3'h5
// vector offsets
`define CPSM_VEC_POR_PC  32'h00000000
`define CPSM_VEC_POR_SP  32'h00000004
`define CPSM_VEC_MAN_PC  32'h00000008
`define CPSM_VEC_MAN_SP  32'h0000000C
`define CPSM_VEC_DMAERR  32'h00000028
`define CPSM_VEC_NMI     32'h0000002C
`define CPSM_VEC_SHIFT   2
// status register mask field
`define CPSM_SR_IMASK_LO 4
`define CPSM_SR_IMASK_HI 7
`define CPSM_IMASK_ALL   4'hF
`define CPSM_VBR_RESET   32'h00000000
// boot config encodings
`define CPSM_MODE0       3'h0
`define CPSM_MODE1       3'h1
`define CPSM_MODE2       3'h2
`define CPSM_MODE7       3'h7
// oscillator settling time in ns
`define CPSM_SETTLE_NS   2000000
`define CPSM_CLK_NS      100
`define CPSM_VEC_DEPTH   256
`endif

// ---- sim/cpsm_ctrl_asserts.sv ----
// assertion checker for the cpu state controller
`timescale 1ns/1ps
module cpsm_ctrl_asserts #(
	parameter SETTLE_CYC = 8
) (
	// clock, reset, pins
	input wire        mclk,
	input wire        nrst,
	input wire        chip_init_pin_n,
	input wire        nmi_pin,
	input wire [2:0]  boot_config_pins,
	input wire        halt_exec,
	input wire        deep_halt_select,
	// state and results
	input wire [2:0]  cpu_state,
	input wire        cpu_run,
	input wire        clock_run,
	input wire        osc_run,
	input wire        bus_grant,
	input wire        module_rst,
	input wire        stack_wr,
	input wire [31:0] stack_addr,
	input wire        ctx_load,
	input wire [31:0] vector_base_reg,
	input wire [3:0]  sr_imask,
	input wire [2:0]  op_mode,
	input wire        area0_16bit
);
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!nrst);
	// marks that the next context load ends a reset, not an interrupt
	reg from_rst_r;
	always @(posedge mclk or negedge nrst) begin
		if (!nrst)
			from_rst_r <= 1'b1;
		else if (cpu_state == 3'h0)
			from_rst_r <= 1'b1;
		else if (ctx_load)
			from_rst_r <= 1'b0;
	end
	a_state_legal: assert property (
		cpu_state <= 3'h4) else $error("state code out of range");
	a_stack_order: assert property (
		$rose(stack_wr) |=> stack_wr && stack_addr == $past(stack_addr) - 32'h4) else $error("bad push order");
	a_sleep_entry: assert property (
		cpu_state == 3'h3 && halt_exec && !deep_halt_select |=> cpu_state == 3'h4 && clock_run && !cpu_run)
		else $error("sleep not entered");
	a_standby_entry: assert property (
		cpu_state == 3'h3 && halt_exec && deep_halt_select |=> cpu_state == 3'h4 && !clock_run && !osc_run
		&& module_rst) else $error("standby not entered");
	a_standby_hold: assert property (
		cpu_state == 3'h4 && !osc_run && !nmi_pin && chip_init_pin_n |=> cpu_state == 3'h4)
		else $error("standby left without nmi or reset");
	a_settle_wait: assert property (
		$rose(osc_run) && cpu_state == 3'h4 |-> (cpu_state == 3'h4) [*8]) else $error("settling cut short");
	a_grant_state: assert property (
		bus_grant |-> cpu_state == 3'h2) else $error("grant outside bus release");
	a_mode_map: assert property (
		cpu_state == 3'h3 |-> op_mode == boot_config_pins && area0_16bit == (boot_config_pins == 3'h1))
		else $error("mode decode wrong");
	a_reset_load: assert property (
		ctx_load && from_rst_r |=> sr_imask == 4'hF && vector_base_reg == 32'h0) else $error("reset context wrong");
	c_reset_load: cover property (ctx_load && from_rst_r);
	c_push: cover property ($rose(stack_wr));
	c_grant: cover property (bus_grant);
endmodule
bind cpsm_ctrl cpsm_ctrl_asserts #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.mclk, .nrst, .chip_init_pin_n, .nmi_pin,
	.boot_config_pins, .halt_exec, .deep_halt_select, .cpu_state, .cpu_run, .clock_run, .osc_run, .bus_grant,
	.module_rst, .stack_wr, .stack_addr, .ctx_load, .vector_base_reg, .sr_imask, .op_mode, .area0_16bit);

// ---- sim/cpsm_ctrl_tb.sv ----
// self-checking bench for the cpu state controller
`timescale 1ns/1ps
module cpsm_ctrl_tb;
	reg         mclk, nrst, clk_en, halt_exec, deep_halt_select, irq_req, dma_addr_err, bus_req, io_hiz_select, vec_wr;
	reg  [7:0]  irq_vec_num, vec_wr_idx;
	reg  [3:0]  irq_level;
	reg  [31:0] cur_pc, cur_sp, cur_sr, vec_wr_data;
	wire        chip_init_pin_n, nmi_pin, cpu_run, clock_run, osc_run, bus_grant, io_hold, io_hiz, cpu_rst, module_rst;
	wire        bus_timing_rst, pin_func_rst, por_flag, stack_wr, ctx_load, area0_16bit, area0_rom, prom_mode, mode_reserved;
	wire [2:0]  boot_config_pins, cpu_state, op_mode;
	wire [31:0] stack_addr, stack_data, new_pc, new_sp, vector_base_reg;
	wire [3:0]  sr_imask;
	integer     num_errors, n_checks, cyc, i, n;
	cpsm_sys_model sys (.mclk, .chip_init_pin_n, .nmi_pin, .boot_config_pins);
	cpsm_ctrl #(.SETTLE_CYC(8)) uut (.mclk, .nrst, .clk_en, .chip_init_pin_n, .nmi_pin, .boot_config_pins, .halt_exec,
		.deep_halt_select, .irq_req, .irq_vec_num, .irq_level, .dma_addr_err, .bus_req, .io_hiz_select, .cur_pc,
		.cur_sp, .cur_sr, .vec_wr, .vec_wr_idx, .vec_wr_data, .cpu_state, .cpu_run, .clock_run, .osc_run, .bus_grant,
		.io_hold, .io_hiz, .cpu_rst, .module_rst, .bus_timing_rst, .pin_func_rst, .por_flag, .stack_wr, .stack_addr,
		.stack_data, .ctx_load, .new_pc, .new_sp, .vector_base_reg, .sr_imask, .op_mode, .area0_16bit, .area0_rom,
		.prom_mode, .mode_reserved);
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	function [31:0] vv(input integer k);
		vv = 32'h00004000 + k * 16;
	endfunction
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			num_errors = num_errors + 1;
			$display("Error %0s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task tk;
		@(posedge mclk);
		#1;
	endtask
	// sel 0 waits for a context load, 1 for a push, 2 for a grant
	task wait_hi(input integer sel);
		n = 0;
		do begin
			tk;
			n = n + 1;
		end while (!(sel == 0 ? ctx_load === 1'b1 : sel == 1 ? stack_wr === 1'b1 : bus_grant === 1'b1) && n < 300);
		chk("wait", n < 300, 1'b1);
	endtask
	task halt(input logic sel);
		@(posedge mclk);
		halt_exec <= 1'b1;
		deep_halt_select <= sel;
		io_hiz_select <= sel;
		@(posedge mclk);
		halt_exec <= 1'b0;
		#1;
	endtask
	task complete_run;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc = cyc + 1;
		if (cyc == 6000) begin
			num_errors = num_errors + 1;
			complete_run;
		end
	end
	initial begin
		{nrst, clk_en, halt_exec, deep_halt_select, irq_req, dma_addr_err, bus_req, io_hiz_select, vec_wr} = 9'h080;
		{irq_vec_num, vec_wr_idx, irq_level} = 20'h00000;
		{cur_pc, cur_sp, cur_sr, vec_wr_data} = {32'h00001234, 32'h00008000, 32'h000000F0, 32'h00000000};
		num_errors = 0;
		n_checks = 0;
		cyc = 0;
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		for (i = 0; i < 13; i = i + 1) begin
			@(posedge mclk);
			vec_wr <= 1'b1;
			vec_wr_idx <= (i == 12) ? 8'h40 : i[7:0];
			vec_wr_data <= vv((i == 12) ? 64 : i);
		end
		@(posedge mclk);
		vec_wr <= 1'b0;
		#1;
		chk("rst_st", {cpu_state, bus_timing_rst, cpu_rst}, 5'h03);
		sys.release_init;
		wait_hi(0);
		chk("por_pc", new_pc, vv(0));
		chk("por_sp", new_sp, vv(1));
		tk;
		chk("imask", sr_imask, 4'hF);
		chk("vbr", vector_base_reg, 32'h00000000);
		chk("por", por_flag, 1'b1);
		chk("mode", {op_mode, area0_16bit, area0_rom, prom_mode, mode_reserved}, 7'h18);
		tk;
		chk("exec", {cpu_state, cpu_run, cpu_rst}, 5'h0E);
		sys.set_nmi(1'b0);
		$display("test por done");
		@(posedge mclk);
		irq_req <= 1'b1;
		irq_level <= 4'h5;
		irq_vec_num <= 8'h40;
		wait_hi(1);
		chk("push_sr", {stack_addr, stack_data}, {32'h00007FFC, 32'h000000F0});
		@(posedge mclk);
		irq_req <= 1'b0;
		#1;
		chk("push_pc", {stack_addr, stack_data}, {32'h00007FF8, 32'h00001234});
		wait_hi(0);
		chk("irq_pc", new_pc, vv(64));
		tk;
		chk("irq_mask", sr_imask, 4'h5);
		$display("test irq done");
		halt(1'b0);
		chk("slp_st", {cpu_state, clock_run, cpu_run, io_hold}, 6'h25);
		@(posedge mclk);
		dma_addr_err <= 1'b1;
		@(posedge mclk);
		dma_addr_err <= 1'b0;
		wait_hi(0);
		chk("dma_pc", new_pc, vv(10));
		$display("test sleep done");
		halt(1'b1);
		chk("sby_st", {cpu_state, clock_run, osc_run, module_rst, io_hiz, io_hold}, 8'h86);
		@(posedge mclk);
		irq_req <= 1'b1;
		repeat (10) @(posedge mclk);
		irq_req <= 1'b0;
		#1;
		chk("sby_hold", cpu_state, 3'h4);
		sys.set_nmi(1'b1);
		wait_hi(0);
		chk("settle", n > 8, 1'b1);
		chk("nmi_pc", new_pc, vv(11));
		$display("test standby done");
		@(posedge mclk);
		bus_req <= 1'b1;
		wait_hi(2);
		chk("grant_st", cpu_state, 3'h2);
		@(posedge mclk);
		bus_req <= 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		chk("ungrant", {bus_grant, cpu_state}, 4'h3);
		$display("test busrel done");
		sys.hold_init(1'b0);
		repeat (6) @(posedge mclk);
		#1;
		chk("man_rst", {cpu_state, module_rst, bus_timing_rst, pin_func_rst}, 6'h04);
		sys.release_init;
		wait_hi(0);
		chk("man_vec", {new_pc, new_sp}, {vv(2), vv(3)});
		tk;
		chk("man_por", por_flag, 1'b0);
		$display("test manual done");
		complete_run;
	end
endmodule

// ---- sim/cpsm_sys_model.sv ----
// system-side model driving the reset, nmi and strap pins
`timescale 1ns/1ps
module cpsm_sys_model #(
	parameter BOOT = 3'h1
) (
	// clock
	input  wire       mclk,
	// pins into the device
	output reg        chip_init_pin_n,
	output reg        nmi_pin,
	output reg  [2:0] boot_config_pins
);
	initial begin
		chip_init_pin_n = 1'b0;
		nmi_pin = 1'b1;
		boot_config_pins = BOOT;
	end
	// nmi settles one edge ahead so the reset type is never ambiguous
	task hold_init(input logic lvl);
		@(posedge mclk);
		nmi_pin <= lvl;
		@(posedge mclk);
		chip_init_pin_n <= 1'b0;
	endtask
	task release_init;
		@(posedge mclk);
		chip_init_pin_n <= 1'b1;
	endtask
	task set_nmi(input logic lvl);
		@(posedge mclk);
		nmi_pin <= lvl;
	endtask
endmodule
